// file: verilog/ppmc_pkg.sv
// Shared offsets, field positions, reset values and states of the port config bank
package ppmc_pkg;

  // Register indices; byte address is four times {port, index}
  localparam logic [11:0] IDX_AUTO_XOVER   = 12'h138;
  localparam logic [11:0] IDX_SPECIAL      = 12'h13C;
  localparam logic [11:0] IDX_PHY_CTRL     = 12'h13E;
  localparam logic [11:0] IDX_MP_CTRL0     = 12'h300;
  localparam logic [11:0] IDX_MP_CTRL1     = 12'h301;
  localparam logic [1:0]  MEDIA_PORT       = 2'h3;
  localparam int          ADDR_W           = 16;

  // Field positions
  localparam int XOVER_OFF_BIT    = 6;
  localparam int FORCE_MDI_BIT    = 7;
  localparam int SINGLE_IND_BIT   = 9;
  localparam int JABBER_EN_BIT    = 9;
  localparam int SPD1000_BIT      = 6;
  localparam int SPD100_BIT       = 5;
  localparam int SPD10_BIT        = 4;
  localparam int DUPLEX_BIT       = 3;
  localparam int MASTER_BIT       = 2;
  localparam int MP_DUPLEX_BIT    = 6;
  localparam int MP_TXFC_BIT      = 5;
  localparam int MP_SPD100_BIT    = 4;
  localparam int MP_RXFC_BIT      = 3;
  localparam int MP_GIG_BIT       = 6;

  // Values after reset and writable masks
  localparam logic [15:0] AUTO_XOVER_RST   = 16'h2400;
  localparam logic [15:0] SPECIAL_RST      = 16'hF800;
  localparam logic [15:0] PHY_CTRL_RST     = 16'h0300;
  localparam logic [15:0] PHY_CTRL_RW_MASK = 16'hF382;
  localparam logic [7:0]  MP_CTRL0_RST     = 8'h50;
  localparam logic [7:0]  MP_CTRL0_RW_MASK = 8'h7F;
  localparam logic [7:0]  MP_CTRL1_RST     = 8'h08;

  // Resolved speed codes
  localparam logic [1:0] SPEED_10    = 2'h0;
  localparam logic [1:0] SPEED_100   = 2'h1;
  localparam logic [1:0] SPEED_1000  = 2'h2;

  // Jabber limit in clock cycles
  localparam int JABBER_LIMIT_CYCLES = 2048;

  typedef enum logic {BUS_IDLE, BUS_DONE} ppmc_bus_state_t;

endpackage : ppmc_pkg

// file: verilog/ppmc_copper_port.sv
// Per copper port crossover, workaround and control/status registers
`timescale 1ns/10ps
module ppmc_copper_port #(
  parameter int JABBER_LIMIT = ppmc_pkg::JABBER_LIMIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register writes
  input  wire logic        wr_xover,
  input  wire logic        wr_special,
  input  wire logic        wr_phy_ctrl,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] wmask,
  // Resolved PHY state
  input  wire logic        link_resolved,
  input  wire logic [1:0]  speed_code,
  input  wire logic        duplex_full,
  input  wire logic        master_role,
  input  wire logic        tx_active,
  // Register readout
  output logic      [15:0] xover_rd,
  output logic      [15:0] special_rd,
  output logic      [15:0] phy_ctrl_rd,
  // Controls
  output logic             auto_xover_en,
  output logic             force_mdi,
  output logic             single_indicator_fix,
  output logic             jabber_en,
  output logic             jabber_detect
);
  import ppmc_pkg::*;

  localparam int CW = $clog2(JABBER_LIMIT + 1);

  logic [15:0]   xover;
  logic [15:0]   special;
  logic [15:0]   phy_ctrl;
  logic [CW-1:0] jab_cnt;
  logic [2:0]    speed_onehot;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xover <= AUTO_XOVER_RST;
    end else if (wr_xover) begin
      xover <= (xover & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      special <= SPECIAL_RST;
    end else if (wr_special) begin
      special <= (special & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_ctrl <= PHY_CTRL_RST;
    end else if (wr_phy_ctrl) begin
      phy_ctrl <= (phy_ctrl & ~(wmask & PHY_CTRL_RW_MASK)) | (wdata & wmask & PHY_CTRL_RW_MASK);
    end
  end

  // Crossover controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_xover_en <= 1'b1;
      force_mdi     <= 1'b0;
    end else begin
      auto_xover_en <= ~xover[XOVER_OFF_BIT];
      force_mdi     <= xover[XOVER_OFF_BIT] & xover[FORCE_MDI_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_indicator_fix <= 1'b0;
      jabber_en            <= 1'b1;
    end else begin
      single_indicator_fix <= special[SINGLE_IND_BIT];
      jabber_en            <= phy_ctrl[JABBER_EN_BIT];
    end
  end

  // Jabber counter runs only while enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jab_cnt       <= '0;
      jabber_detect <= 1'b0;
    end else if (!phy_ctrl[JABBER_EN_BIT] || !tx_active) begin
      jab_cnt       <= '0;
      jabber_detect <= 1'b0;
    end else if (jab_cnt == CW'(JABBER_LIMIT)) begin
      jabber_detect <= 1'b1;
    end else begin
      jab_cnt <= jab_cnt + CW'(1);
    end
  end

  // At most one speed bit, none without a resolved link
  always_comb begin
    speed_onehot = 3'h0;
    if (link_resolved) begin
      case (speed_code)
        SPEED_10:   speed_onehot = 3'h1;
        SPEED_100:  speed_onehot = 3'h2;
        SPEED_1000: speed_onehot = 3'h4;
        default:    speed_onehot = 3'h0;
      endcase
    end
  end

  always_comb begin
    xover_rd                 = xover;
    special_rd               = special;
    phy_ctrl_rd              = phy_ctrl & PHY_CTRL_RW_MASK;
    phy_ctrl_rd[SPD1000_BIT] = speed_onehot[2];
    phy_ctrl_rd[SPD100_BIT]  = speed_onehot[1];
    phy_ctrl_rd[SPD10_BIT]   = speed_onehot[0];
    phy_ctrl_rd[DUPLEX_BIT]  = link_resolved & duplex_full;
    phy_ctrl_rd[MASTER_BIT]  = link_resolved & master_role;
  end

endmodule : ppmc_copper_port

// file: verilog/ppmc_regs.sv
// Avalon-MM register bank for copper ports 1-2 and the media port 3 MAC
`timescale 1ns/10ps
// What this block does
// - Crossover-disable bit 6 set turns off automatic crossover; reset leaves it on.
// - With crossover off, forced-polarity bit 7 picks MDI at 1, MDI-X at 0.
// - Forced-polarity bit has no effect while automatic crossover is on.
// - Jabber counter runs only while jabber-enable bit 9 is set; reset sets it.
// - Bits 6,5,4 report resolved 1000/100/10 speed; bit 3 reports full duplex.
// - Bit 2 reports gigabit master at 1, slave at 0.
// - Port 3 MAC runs full duplex while bit 6 is 1, the reset value.
// - Port 3 transmit flow control only while bit 5 set; off after reset.
// - Port 3 receive flow control only while bit 3 set; off after reset.
// - The 10/100 speed bit 4 is ignored when gigabit is selected.
// - Without gigabit, port 3 runs 100 Mb/s at bit 4 high, else 10.
// - Companion register bit 6 high selects gigabit; low defers to bit 4.
module ppmc_regs #(
  parameter int          JABBER_LIMIT = ppmc_pkg::JABBER_LIMIT_CYCLES,
  parameter logic        GIG_DEFAULT  = 1'b0
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Avalon-MM slave
  input  wire logic [ppmc_pkg::ADDR_W-1:0]  address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  // Resolved state of copper ports 1-2, bit 0 is port 1
  input  wire logic [1:0]                   link_resolved,
  input  wire logic [3:0]                   speed_code,
  input  wire logic [1:0]                   duplex_full,
  input  wire logic [1:0]                   master_role,
  input  wire logic [1:0]                   tx_active,
  // Copper port controls
  output logic      [1:0]                   auto_xover_en,
  output logic      [1:0]                   force_mdi,
  output logic      [1:0]                   single_indicator_fix,
  output logic      [1:0]                   jabber_en,
  output logic      [1:0]                   jabber_detect,
  // Media port 3 MAC controls
  output logic                              mp_full_duplex,
  output logic                              mp_tx_flow_en,
  output logic                              mp_rx_flow_en,
  output logic      [1:0]                   mp_speed_code
);
  import ppmc_pkg::*;

  localparam int IW = ADDR_W - 2;

  // Register index decode
  function automatic logic hit(input logic [IW-1:0] idx, input logic [1:0] port,
                               input logic [11:0] off);
    hit = (idx[IW-1:12] == port) && (idx[11:0] == off);
  endfunction : hit

  ppmc_bus_state_t bus_state;
  logic [IW-1:0]   idx;
  logic [15:0]     wmask;
  logic            wr_take;
  logic [31:0]     next_readdata;

  logic [7:0]      mp_ctrl0;
  logic [7:0]      mp_ctrl1;

  logic [15:0]     xover_rd    [2];
  logic [15:0]     special_rd  [2];
  logic [15:0]     phy_ctrl_rd [2];

  assign idx   = address[ADDR_W-1:2];
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // One wait cycle, then the request is taken
  assign waitrequest = (read | write) & (bus_state != BUS_DONE);
  assign wr_take     = write & (bus_state == BUS_DONE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (read | write) begin
            bus_state <= BUS_DONE;
          end
        end
        BUS_DONE: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read data captured ahead and held through the taking edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && bus_state == BUS_IDLE) begin
      readdata <= next_readdata;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    for (int p = 0; p < 2; p++) begin
      if (hit(idx, 2'(p + 1), IDX_AUTO_XOVER)) begin
        next_readdata = {16'h0000, xover_rd[p]};
      end
      if (hit(idx, 2'(p + 1), IDX_SPECIAL)) begin
        next_readdata = {16'h0000, special_rd[p]};
      end
      if (hit(idx, 2'(p + 1), IDX_PHY_CTRL)) begin
        next_readdata = {16'h0000, phy_ctrl_rd[p]};
      end
    end
    if (hit(idx, MEDIA_PORT, IDX_MP_CTRL0)) begin
      next_readdata = {24'h000000, mp_ctrl0};
    end
    if (hit(idx, MEDIA_PORT, IDX_MP_CTRL1)) begin
      next_readdata = {24'h000000, mp_ctrl1};
    end
  end

  // Copper ports 1-2
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_copper
      ppmc_copper_port #(
        .JABBER_LIMIT (JABBER_LIMIT)
      ) u_port (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .wr_xover             (wr_take && hit(idx, 2'(g + 1), IDX_AUTO_XOVER)),
        .wr_special           (wr_take && hit(idx, 2'(g + 1), IDX_SPECIAL)),
        .wr_phy_ctrl          (wr_take && hit(idx, 2'(g + 1), IDX_PHY_CTRL)),
        .wdata                (writedata[15:0]),
        .wmask                (wmask),
        .link_resolved        (link_resolved[g]),
        .speed_code           (speed_code[2*g+1:2*g]),
        .duplex_full          (duplex_full[g]),
        .master_role          (master_role[g]),
        .tx_active            (tx_active[g]),
        .xover_rd             (xover_rd[g]),
        .special_rd           (special_rd[g]),
        .phy_ctrl_rd          (phy_ctrl_rd[g]),
        .auto_xover_en        (auto_xover_en[g]),
        .force_mdi            (force_mdi[g]),
        .single_indicator_fix (single_indicator_fix[g]),
        .jabber_en            (jabber_en[g]),
        .jabber_detect        (jabber_detect[g])
      );
    end
  endgenerate

  // Media port MAC control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mp_ctrl0 <= MP_CTRL0_RST;
    end else if (wr_take && byteenable[0] && hit(idx, MEDIA_PORT, IDX_MP_CTRL0)) begin
      mp_ctrl0 <= writedata[7:0] & MP_CTRL0_RW_MASK;
    end
  end

  // Companion register holding the gigabit select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mp_ctrl1 <= MP_CTRL1_RST;
      mp_ctrl1[MP_GIG_BIT] <= GIG_DEFAULT;
    end else if (wr_take && byteenable[0] && hit(idx, MEDIA_PORT, IDX_MP_CTRL1)) begin
      mp_ctrl1 <= writedata[7:0];
    end
  end

  // Media port MAC mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mp_full_duplex <= 1'b1;
      mp_tx_flow_en  <= 1'b0;
      mp_rx_flow_en  <= 1'b0;
    end else begin
      mp_full_duplex <= mp_ctrl0[MP_DUPLEX_BIT];
      mp_tx_flow_en  <= mp_ctrl0[MP_TXFC_BIT];
      mp_rx_flow_en  <= mp_ctrl0[MP_RXFC_BIT];
    end
  end

  // Media port speed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mp_speed_code <= SPEED_100;
    end else if (mp_ctrl1[MP_GIG_BIT]) begin
      mp_speed_code <= SPEED_1000;
    end else if (mp_ctrl0[MP_SPD100_BIT]) begin
      mp_speed_code <= SPEED_100;
    end else begin
      mp_speed_code <= SPEED_10;
    end
  end

endmodule : ppmc_regs

// file: bench/ppmc_regs_monitor.sv
// Assertion checker for the port config register bank
`timescale 1ns/10ps
module ppmc_regs_monitor #(
  parameter int   JABBER_LIMIT = ppmc_pkg::JABBER_LIMIT_CYCLES,
  parameter logic GIG_DEFAULT  = 1'b0
) (
  // Clock, reset and bus
  input wire logic [ppmc_pkg::ADDR_W-1:0] address,
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [31:0]                 writedata,
  input wire logic [3:0]                  byteenable,
  input wire logic [31:0]                 readdata,
  input wire logic                        waitrequest,
  // Status and controls
  input wire logic [1:0]                  link_resolved,
  input wire logic [3:0]                  speed_code,
  input wire logic [1:0]                  duplex_full,
  input wire logic [1:0]                  master_role,
  input wire logic [1:0]                  auto_xover_en,
  input wire logic [1:0]                  force_mdi,
  input wire logic [1:0]                  jabber_en,
  input wire logic [1:0]                  jabber_detect,
  input wire logic                        mp_full_duplex,
  input wire logic                        mp_tx_flow_en,
  input wire logic                        mp_rx_flow_en,
  input wire logic [1:0]                  mp_speed_code
);
  import ppmc_pkg::*;
  logic       wr_ok;
  logic       rd_ok;
  logic       lk_q;
  logic       dp_q;
  logic       ms_q;
  logic [1:0] sc_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  assign wr_ok = write && !waitrequest;
  assign rd_ok = read && !waitrequest;
  // Status seen when the read was first presented
  always_ff @(posedge clk) begin
    {lk_q, sc_q, dp_q, ms_q} <= {link_resolved[0], speed_code[1:0], duplex_full[0],
                                 master_role[0]};
  end
  xover_disable_a: assert property (
    wr_ok && address == 16'h44E0 && byteenable[0] |-> ##2 auto_xover_en[0] == !$past(writedata[6], 2))
    else $error("crossover enable wrong");
  forced_mdi_a: assert property (
    wr_ok && address == 16'h44E0 && byteenable[0]
    |-> ##2 force_mdi[0] == ($past(writedata[6], 2) && $past(writedata[7], 2)))
    else $error("forced mdi wrong");
  jabber_enable_a: assert property (
    wr_ok && address == 16'h44F8 && byteenable[1] |-> ##2 jabber_en[0] == $past(writedata[9], 2))
    else $error("jabber enable wrong");
  jabber_stop_a: assert property (!jabber_en[0] ##1 !jabber_en[0] |-> !jabber_detect[0])
    else $error("jabber detect while disabled");
  speed_status_a: assert property (
    rd_ok && address == 16'h44F8
    |-> readdata[6:4] == ({3{lk_q}} & {sc_q == 2'h2, sc_q == 2'h1, sc_q == 2'h0}))
    else $error("speed status wrong");
  duplex_role_a: assert property (
    rd_ok && address == 16'h44F8 |-> readdata[3:2] == {lk_q & dp_q, lk_q & ms_q})
    else $error("duplex or role status wrong");
  media_ctrl_a: assert property (
    wr_ok && address == 16'hCC00 && byteenable[0] |-> ##2 {mp_full_duplex, mp_tx_flow_en,
    mp_rx_flow_en} == {$past(writedata[6], 2), $past(writedata[5], 2), $past(writedata[3], 2)})
    else $error("media port controls wrong");
  media_speed_a: assert property (
    wr_ok && address == 16'hCC00 && byteenable[0] |-> ##2 mp_speed_code ==
    ($past(mp_speed_code, 2) == 2'h2 ? 2'h2 : {1'b0, $past(writedata[4], 2)}))
    else $error("media port speed wrong");
  gig_select_a: assert property (
    wr_ok && address == 16'hCC04 && byteenable[0] && writedata[6] |-> ##2 mp_speed_code == 2'h2)
    else $error("gigabit select ignored");
  one_wait_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("wait cycle count wrong");
endmodule : ppmc_regs_monitor

bind ppmc_regs ppmc_regs_monitor #(.JABBER_LIMIT(JABBER_LIMIT), .GIG_DEFAULT(GIG_DEFAULT)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .link_resolved(link_resolved), .speed_code(speed_code),
  .duplex_full(duplex_full), .master_role(master_role), .auto_xover_en(auto_xover_en),
  .force_mdi(force_mdi), .jabber_en(jabber_en), .jabber_detect(jabber_detect),
  .mp_full_duplex(mp_full_duplex), .mp_tx_flow_en(mp_tx_flow_en),
  .mp_rx_flow_en(mp_rx_flow_en), .mp_speed_code(mp_speed_code));

// file: bench/tb.sv
// Self-checking bench for the port config register bank
`timescale 1ns/10ps
module tb;
  import ppmc_pkg::*;
  logic        clk, sys_rst, read, write, waitrequest;
  logic [15:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  byteenable, speed_code;
  logic [1:0]  link_resolved, duplex_full, master_role, tx_active;
  logic [1:0]  auto_xover_en, force_mdi, single_indicator_fix, jabber_en, jabber_detect;
  logic        mp_full_duplex, mp_tx_flow_en, mp_rx_flow_en;
  logic [1:0]  mp_speed_code;
  int          n_fail, comparisons;

  ppmc_regs #(.JABBER_LIMIT(8), .GIG_DEFAULT(1'b0)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .link_resolved(link_resolved), .speed_code(speed_code),
    .duplex_full(duplex_full), .master_role(master_role), .tx_active(tx_active),
    .auto_xover_en(auto_xover_en), .force_mdi(force_mdi),
    .single_indicator_fix(single_indicator_fix), .jabber_en(jabber_en),
    .jabber_detect(jabber_detect), .mp_full_duplex(mp_full_duplex),
    .mp_tx_flow_en(mp_tx_flow_en), .mp_rx_flow_en(mp_rx_flow_en),
    .mp_speed_code(mp_speed_code));

  task automatic complete_run();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= wr;
    read       <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 16);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_fail++;
      complete_run();
    end
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(q, exp);
  endtask : rd

  function automatic logic [31:0] ctl_exp(logic [15:0] s, logic lk, logic [1:0] c,
                                          logic dp, logic ms);
    return {16'h0, (s & PHY_CTRL_RW_MASK) |
            {9'h0, lk & c == 2'h2, lk & c == 2'h1, lk & c == 2'h0, lk & dp, lk & ms, 2'h0}};
  endfunction : ctl_exp

  // Reset, then every control and one port's copy of each register at its value after reset
  task automatic reset_check();
    {link_resolved, speed_code, duplex_full, master_role, tx_active} <= 12'h0;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({auto_xover_en, force_mdi, single_indicator_fix, jabber_en}, 32'hC3);
    chk(jabber_detect, 32'h0);
    chk({mp_full_duplex, mp_tx_flow_en, mp_rx_flow_en, mp_speed_code}, 32'h11);
    rd(16'h44E0, 32'h2400);
    rd(16'h84F0, 32'hF800);
    rd(16'h44F8, 32'h0300);
    rd(16'hCC00, 32'h50);
    rd(16'hCC04, 32'h08);
  endtask : reset_check

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    logic [15:0] d;
    logic [1:0]  lk, dp, ms;
    logic [3:0]  sc;
    logic        g;
    {sys_rst, read, write, address, writedata, byteenable} = {3'h4, 52'h0};
    {link_resolved, speed_code, duplex_full, master_role, tx_active} = 12'h0;
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'hC538DA37));
    reset_check();
    bus(1'b1, 16'h0000, 32'hFFFF, 4'hF);
    rd(16'h0000, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = {8'h24, i[1], i[0], 6'h15};
      bus(1'b1, 16'h44E0, {16'h0, d}, 4'h3);
      bus(1'b1, 16'h84E0, {16'h0, d}, 4'h3);
      repeat (2) @(posedge clk);
      chk({auto_xover_en, force_mdi}, {28'h0, {2{~i[0]}}, {2{i[0] & i[1]}}});
      rd(16'h84E0, {16'h0, d});
    end
    bus(1'b1, 16'h44E0, 32'h0000, 4'h2);
    rd(16'h44E0, 32'h00D5);
    bus(1'b1, 16'h44F0, 32'hFA00, 4'h3);
    repeat (2) @(posedge clk);
    chk(single_indicator_fix, 32'h1);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom());
      {lk, sc, dp, ms} = 10'($urandom());
      link_resolved <= lk;
      speed_code    <= sc;
      duplex_full   <= dp;
      master_role   <= ms;
      bus(1'b1, 16'h44F8, {16'h0, d}, 4'h3);
      repeat (2) @(posedge clk);
      chk(jabber_en[0], d[9]);
      rd(16'h44F8, ctl_exp(d, lk[0], sc[1:0], dp[0], ms[0]));
    end
    bus(1'b1, 16'h44F8, 32'h0200, 4'h3);
    tx_active <= 2'h1;
    repeat (12) @(posedge clk);
    chk(jabber_detect[0], 1'b1);
    bus(1'b1, 16'h44F8, 32'h0000, 4'h3);
    repeat (2) @(posedge clk);
    chk(jabber_detect[0], 1'b0);
    tx_active <= 2'h0;
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom());
      g = (i == 1) ? 1'b1 : 1'(i[2] ^ d[8]);
      bus(1'b1, 16'hCC04, {24'h0, 1'b0, g, 6'h08}, 4'h1);
      bus(1'b1, 16'hCC00, {16'h0, d}, 4'h1);
      repeat (2) @(posedge clk);
      chk({mp_full_duplex, mp_tx_flow_en, mp_rx_flow_en}, 32'({d[6:5], d[3]}));
      chk(mp_speed_code, g ? 32'h2 : {31'h0, d[4]});
      rd(16'hCC00, {25'h0, d[6:0]});
    end
    reset_check();
    complete_run();
  end
endmodule : tb
